// ### logic/psc_stats.sv
// per-port statistics counter bank with indirect read-clear access
// assumes the mac datapath pulses one classified frame per port per cycle
`timescale 1ns/10ps
`default_nettype none
module psc_stats
  import psc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NPORT-1:0] rx_valid,
  input wire logic [NPORT-1:0][LEN_W-1:0] rx_len,
  input wire logic [NPORT-1:0] rx_crc_ok,
  input wire logic [NPORT-1:0] rx_sym_err,
  input wire logic [NPORT-1:0] rx_odd_bits,
  input wire logic [NPORT-1:0] rx_preamble_ok,
  input wire logic [NPORT-1:0] rx_high_prio,
  input wire logic [NPORT-1:0] rx_bcast,
  input wire logic [NPORT-1:0] rx_mcast,
  input wire logic [NPORT-1:0] rx_ctrl_type,
  input wire logic [NPORT-1:0] rx_halt_da_op,
  input wire logic [NPORT-1:0] rx_drop,
  input wire logic [NPORT-1:0] tx_valid,
  input wire logic [NPORT-1:0][LEN_W-1:0] tx_len,
  input wire logic [NPORT-1:0] tx_ok,
  input wire logic [NPORT-1:0] tx_high_prio,
  input wire logic [NPORT-1:0] tx_bcast,
  input wire logic [NPORT-1:0] tx_mcast,
  input wire logic [NPORT-1:0] tx_ctrl_type,
  input wire logic [NPORT-1:0] tx_halt_da_op,
  input wire logic [NPORT-1:0] tx_late,
  input wire logic [NPORT-1:0] tx_waited,
  input wire logic [NPORT-1:0] tx_half_duplex,
  input wire logic [NPORT-1:0][4:0] tx_clashes,
  input wire logic [NPORT-1:0] tx_abort,
  input wire logic [NPORT-1:0] tx_drop
);

  psc_state_t s;
  psc_state_t n;
  logic [NPORT-1:0][NCNT-1:0][LEN_W-1:0] inc;
  logic [NPORT-1:0][31:0] csr;
  logic wr_go;
  logic rd_go;
  logic [31:0] wmask;
  logic [4:0] wport;
  logic [4:0] rport;
  logic w_glob;
  logic w_port;
  logic r_glob;
  logic r_port;

  // ****************************************
  // per-port frame classification
  // ****************************************
  for (genvar p = 0; p < NPORT; p++) begin : g_port
    logic [NCNT-1:0][LEN_W-1:0] amt;
    logic [LEN_W-1:0] maxl;
    logic [LEN_W-1:0] rl;
    logic [LEN_W-1:0] tl;
    logic rerr;
    logic legal;
    logic rgood;
    logic tgood;

    // every frame lands in all classes it qualifies for
    always_comb begin
      rl = rx_len[p];
      tl = tx_len[p];
      maxl = s.maxsel[p] ? LONG_MAX : STD_MAX;
      rerr = !rx_crc_ok[p] || rx_sym_err[p] || rx_odd_bits[p];
      legal = (rl >= MIN_LEN) && (rl <= maxl);
      rgood = !rerr;
      tgood = tx_ok[p];
      amt = '0;
      if (rx_valid[p]) begin
        amt[S_RX_HP_OCT] = rx_high_prio[p] ? rl : '0;
        amt[S_RX_SHORT_GOOD] = LEN_W'(rl < MIN_LEN && rx_crc_ok[p]);
        amt[S_RX_SHORT_BAD] = LEN_W'(rl < MIN_LEN && rerr);
        amt[S_RX_TOO_LONG] = LEN_W'(rl > maxl && rx_crc_ok[p]);
        // short max: long errored; long max: only very long ones
        amt[S_RX_LONG_ERR] = s.maxsel[p] ? LEN_W'(rl > JAB_LONG) :
                             LEN_W'(rl > STD_MAX && rerr);
        amt[S_RX_BAD_SYM] =
          LEN_W'(rx_sym_err[p] && rx_preamble_ok[p] && legal);
        amt[S_RX_FCS] =
          LEN_W'(legal && !rx_odd_bits[p] && !rx_crc_ok[p]);
        amt[S_RX_ODD] =
          LEN_W'(legal && rx_odd_bits[p] && !rx_crc_ok[p]);
        amt[S_RX_CTRL] = LEN_W'(rx_ctrl_type[p]);
        amt[S_RX_HALT] = LEN_W'(rx_ctrl_type[p] && rx_halt_da_op[p] &&
                         rl >= MIN_LEN && rx_crc_ok[p]);
        amt[S_RX_BCAST] = LEN_W'(rgood && rx_bcast[p]);
        amt[S_RX_GROUP] = LEN_W'(rgood && rx_mcast[p] && !rx_bcast[p] &&
                          !rx_ctrl_type[p]);
        amt[S_RX_SINGLE] =
          LEN_W'(rgood && !rx_mcast[p] && !rx_bcast[p]);
        // length bins count bad frames too
        amt[S_RX_BIN0] = LEN_W'(rl == MIN_LEN);
        amt[S_RX_BIN0+1] = LEN_W'(rl > MIN_LEN && rl <= BIN_127);
        amt[S_RX_BIN0+2] = LEN_W'(rl > BIN_127 && rl <= BIN_255);
        amt[S_RX_BIN0+3] = LEN_W'(rl > BIN_255 && rl <= BIN_511);
        amt[S_RX_BIN0+4] = LEN_W'(rl > BIN_511 && rl <= BIN_1023);
        amt[S_RX_BIN0+5] = LEN_W'(rl > BIN_1023 && rl <= STD_MAX);
        amt[S_RX_BIN0+6] = LEN_W'(rl > STD_MAX && rl <= BIN_2000);
        amt[S_RX_BIN0+7] = LEN_W'(rl > BIN_2000);
        amt[S_RX_OCT] = rl;
        amt[S_RX_DROP] = LEN_W'(rx_drop[p]);
      end
      if (tx_valid[p]) begin
        amt[S_TX_HP_OCT] = (tgood && tx_high_prio[p]) ? tl : '0;
        amt[S_TX_LATE] = LEN_W'(tx_late[p]);
        amt[S_TX_HALT] = LEN_W'(tx_ctrl_type[p] && tx_halt_da_op[p] &&
                         tl >= MIN_LEN && tgood);
        amt[S_TX_BCAST] = LEN_W'(tgood && tx_bcast[p]);
        amt[S_TX_GROUP] = LEN_W'(tgood && tx_mcast[p] && !tx_bcast[p] &&
                          !tx_ctrl_type[p]);
        amt[S_TX_SINGLE] =
          LEN_W'(tgood && !tx_mcast[p] && !tx_bcast[p]);
        amt[S_TX_WAITED] = LEN_W'(tx_waited[p]);
        // collisions only mean something in half duplex
        amt[S_TX_CLASH] = tx_half_duplex[p] ?
                          LEN_W'(tx_clashes[p]) : '0;
        amt[S_TX_ABORT] = LEN_W'(tx_abort[p]);
        amt[S_TX_ONE] = LEN_W'(tgood && tx_clashes[p] == 5'h01);
        amt[S_TX_MANY] = LEN_W'(tgood && tx_clashes[p] > 5'h01);
        amt[S_TX_OCT] = tl;
        amt[S_TX_DROP] = LEN_W'(tx_drop[p]);
      end
    end

    assign inc[p] = amt;
    // control/status image as software sees it
    assign csr[p] = {s.ovf[p], 4'h0, s.maxsel[p], s.req[p], s.ffen[p],
                     s.idx[p], 12'h000, s.hi[p]};
  end

  // ****************************************
  // bus decode
  // ****************************************
  assign wr_go = s.awready && s_axi_awvalid && s_axi_wvalid;
  assign rd_go = s.arready && s_axi_arvalid;
  assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                  {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  assign wport = s_axi_awaddr[7:3];
  assign rport = s_axi_araddr[7:3];
  assign w_glob = s_axi_awaddr[ADDR_W-1:2] == GLOBAL_OFS[ADDR_W-1:2];
  assign r_glob = s_axi_araddr[ADDR_W-1:2] == GLOBAL_OFS[ADDR_W-1:2];
  assign w_port = (s_axi_awaddr[11:8] == PORT_PAGE) && (wport < 5'(NPORT));
  assign r_port = (s_axi_araddr[11:8] == PORT_PAGE) && (rport < 5'(NPORT));

  // ****************************************
  // next state
  // ****************************************
  // counters first, then the bus, so a new request is never lost
  always_comb begin
    logic [6:0] sl;
    logic [CNT_W-1:0] base;
    logic [CNT_W:0] sum;
    logic frz;
    logic fls;
    logic ovf_set;
    logic [31:0] merged;
    sl = '0;
    base = '0;
    sum = '0;
    frz = 1'b0;
    fls = 1'b0;
    ovf_set = 1'b0;
    merged = '0;
    n = s;
    for (int p = 0; p < NPORT; p++) begin
      sl = psc_slot_of(s.idx[p]);
      frz = s.glob[GL_FREEZE] && s.ffen[p];
      fls = s.glob[GL_FLUSH] && s.ffen[p];
      ovf_set = 1'b0;
      for (int c = 0; c < NCNT; c++) begin
        if (fls) begin
          n.cnt[p][c] = '0;
        end else begin
          // events in the read cycle start the fresh count
          base = (s.req[p] && sl[6] && sl[5:0] == 6'(c)) ?
                 '0 : s.cnt[p][c];
          sum = {1'b0, base} + (CNT_W+1)'(inc[p][c]);
          if (frz) begin
            n.cnt[p][c] = base;
          end else if (c == S_RX_OCT || c == S_TX_OCT) begin
            n.cnt[p][c] = sum[CNT_W-1:0];
            ovf_set = ovf_set || sum[CNT_W];
          end else begin
            n.cnt[p][c] = {6'h00, sum[NARROW_W-1:0]};
            ovf_set = ovf_set || sum[NARROW_W];
          end
        end
      end
      // snapshot a requested counter and drop the request
      if (s.req[p]) begin
        n.data[p] = sl[6] ? s.cnt[p][sl[5:0]][31:0] : '0;
        n.hi[p] = sl[6] ? s.cnt[p][sl[5:0]][CNT_W-1:32] : '0;
        n.req[p] = 1'b0;
      end
      // a wrap in the read cycle stays visible
      n.ovf[p] = ovf_set || (s.ovf[p] && !s.req[p]);
    end

    // write channel: take address and data together
    if (!s.awready && !s.bvalid && s_axi_awvalid && s_axi_wvalid) begin
      n.awready = 1'b1;
      n.wready = 1'b1;
    end
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (wr_go) begin
      n.awready = 1'b0;
      n.wready = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = (w_glob || w_port) ? RESP_OKAY : RESP_SLVERR;
      if (w_glob && s_axi_wstrb[0]) begin
        n.glob = s_axi_wdata[7:0];
      end
      for (int p = 0; p < NPORT; p++) begin
        if (w_port && wport == 5'(p) && !s_axi_awaddr[2]) begin
          merged = (csr[p] & ~wmask) | (s_axi_wdata & wmask);
          n.idx[p] = merged[CS_IDX_LO +: 8];
          n.ffen[p] = merged[CS_FFEN];
          n.maxsel[p] = merged[CS_MAXSEL];
          n.req[p] = merged[CS_REQ] || s.req[p];
        end
      end
    end

    // read channel
    if (!s.arready && !s.rvalid && s_axi_arvalid) begin
      n.arready = 1'b1;
    end
    if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (rd_go) begin
      n.arready = 1'b0;
      n.rvalid = 1'b1;
      n.rresp = (r_glob || r_port) ? RESP_OKAY : RESP_SLVERR;
      n.rdata = '0;
      if (r_glob) begin
        n.rdata = {24'h000000, s.glob};
      end else if (r_port) begin
        n.rdata = s_axi_araddr[2] ? s.data[rport[2:0]] :
                  csr[rport[2:0]];
      end
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rdata = s.rdata;

  // ****************************************
  // checks on port 0 and on the bus handshakes
  // ****************************************
  logic [6:0] sl0;
  logic [CNT_W-1:0] cur0;
  logic [3:0] cur0_hi;
  logic [NARROW_W-1:0] bin0;
  assign sl0 = psc_slot_of(s.idx[0]);
  assign cur0 = s.cnt[0][sl0[5:0]];
  assign cur0_hi = cur0[CNT_W-1:32];
  assign bin0 = s.cnt[0][S_RX_BIN0][NARROW_W-1:0];

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_wr_taken;
    wr_go;
  endsequence
  sequence s_quiet0;
    !rx_valid[0] && !tx_valid[0];
  endsequence
  sequence s_read0;
    s.req[0] && sl0[6];
  endsequence

  property p_req_done;
    $rose(s.req[0]) |=> !s.req[0];
  endproperty
  a_req_done: assert property (p_req_done)
    else $error("read request not cleared");

  property p_read_clear;
    s_read0 ##0 s_quiet0 ##0 !s.glob[GL_FREEZE] |=>
      s.cnt[0][$past(sl0[5:0])] == '0;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("counter not cleared by read");

  property p_snapshot;
    s_read0 |=> s.data[0] == $past(cur0[31:0]);
  endproperty
  a_snapshot: assert property (p_snapshot)
    else $error("data register does not hold counter");

  property p_top_bits;
    s_read0 |=> s.hi[0] == $past(cur0_hi);
  endproperty
  a_top_bits: assert property (p_top_bits)
    else $error("top counter bits wrong");

  property p_flush;
    s.glob[GL_FLUSH] && s.ffen[0] |=> s.cnt[0] == '0;
  endproperty
  a_flush: assert property (p_flush)
    else $error("flush did not clear counters");

  property p_freeze;
    s.glob[GL_FLUSH:GL_FREEZE] == 2'b01 && s.ffen[0] && !s.req[0] |=>
      $stable(s.cnt[0]);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("frozen counters moved");

  property p_wrap;
    s.cnt[0][S_RX_SHORT_GOOD] == {6'h00, {NARROW_W{1'b1}}} &&
    rx_valid[0] && rx_len[0] < MIN_LEN && rx_crc_ok[0] &&
    s.glob == 8'h00 && !s.req[0] |=>
      s.cnt[0][S_RX_SHORT_GOOD] == '0 && s.ovf[0];
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("counter did not wrap with overflow");

  property p_bin64;
    rx_valid[0] && rx_len[0] == MIN_LEN && s.glob == 8'h00 &&
    !s.req[0] |=> bin0 == $past(bin0) + 30'h00000001;
  endproperty
  a_bin64: assert property (p_bin64)
    else $error("64-byte bin not incremented");

  property p_wr_resp;
    s_wr_taken |=> s.bvalid && !s.awready ##1 s.bvalid || $past(s_axi_bready);
  endproperty
  a_wr_resp: assert property (p_wr_resp)
    else $error("write response missing");

  property p_rhold;
    s.rvalid && !s_axi_rready |=> s.rvalid && $stable(s.rdata);
  endproperty
  a_rhold: assert property (p_rhold)
    else $error("read data dropped before taken");

endmodule
`default_nettype wire

// ### logic/psc_pkg.sv
// per-port statistics counter bank: constants, register map, state type
// assumes a 32-bit axi4-lite slave port and one core clock
package psc_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int NPORT = 7;
  localparam int NCNT = 36;
  localparam int CNT_W = 36;
  localparam int NARROW_W = 30;
  localparam int LEN_W = 16;
  localparam int ADDR_W = 12;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [ADDR_W-1:0] GLOBAL_OFS = 12'h000;
  localparam logic [3:0] PORT_PAGE = 4'h1; // port regs at 0x100 + 8*port
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // per-port control/status fields
  localparam int CS_IDX_LO = 16;
  localparam int CS_FFEN = 24;
  localparam int CS_REQ = 25;
  localparam int CS_MAXSEL = 26;
  localparam int CS_OVF = 31;
  // global control fields
  localparam int GL_FREEZE = 6;
  localparam int GL_FLUSH = 7;
  localparam logic [7:0] WIDE_IDX_BASE = 8'h80;

  // ****************************************
  // counter slots (index 0x00-0x1F direct, 0x80-0x83 at 32-35)
  // ****************************************
  localparam int S_RX_HP_OCT = 0;
  localparam int S_RX_SHORT_GOOD = 1;
  localparam int S_RX_SHORT_BAD = 2;
  localparam int S_RX_TOO_LONG = 3;
  localparam int S_RX_LONG_ERR = 4;
  localparam int S_RX_BAD_SYM = 5;
  localparam int S_RX_FCS = 6;
  localparam int S_RX_ODD = 7;
  localparam int S_RX_CTRL = 8;
  localparam int S_RX_HALT = 9;
  localparam int S_RX_BCAST = 10;
  localparam int S_RX_GROUP = 11;
  localparam int S_RX_SINGLE = 12;
  localparam int S_RX_BIN0 = 13; // eight length bins, 13..20
  localparam int S_TX_HP_OCT = 21;
  localparam int S_TX_LATE = 22;
  localparam int S_TX_HALT = 23;
  localparam int S_TX_BCAST = 24;
  localparam int S_TX_GROUP = 25;
  localparam int S_TX_SINGLE = 26;
  localparam int S_TX_WAITED = 27;
  localparam int S_TX_CLASH = 28;
  localparam int S_TX_ABORT = 29;
  localparam int S_TX_ONE = 30;
  localparam int S_TX_MANY = 31;
  localparam int S_RX_OCT = 32;
  localparam int S_TX_OCT = 33;
  localparam int S_RX_DROP = 34;
  localparam int S_TX_DROP = 35;

  // ****************************************
  // frame length limits
  // ****************************************
  localparam logic [LEN_W-1:0] MIN_LEN = 16'h0040;
  localparam logic [LEN_W-1:0] STD_MAX = 16'h05F2;
  localparam logic [LEN_W-1:0] LONG_MAX = 16'h0600;
  localparam logic [LEN_W-1:0] JAB_LONG = 16'h077C;
  localparam logic [LEN_W-1:0] BIN_127 = 16'h007F;
  localparam logic [LEN_W-1:0] BIN_255 = 16'h00FF;
  localparam logic [LEN_W-1:0] BIN_511 = 16'h01FF;
  localparam logic [LEN_W-1:0] BIN_1023 = 16'h03FF;
  localparam logic [LEN_W-1:0] BIN_2000 = 16'h07D0;

  typedef struct packed {
    logic [NPORT-1:0][NCNT-1:0][CNT_W-1:0] cnt;
    logic [NPORT-1:0][7:0] idx;
    logic [NPORT-1:0] req;
    logic [NPORT-1:0] ffen;
    logic [NPORT-1:0] maxsel;
    logic [NPORT-1:0] ovf;
    logic [NPORT-1:0][31:0] data;
    logic [NPORT-1:0][3:0] hi;
    logic [7:0] glob;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } psc_state_t;

  // index to {valid, slot}
  function automatic logic [6:0] psc_slot_of(input logic [7:0] i);
    logic [6:0] r;
    r = 7'h00;
    if (i[7:5] == 3'h0) begin
      r = {2'b10, i[4:0]};
    end else if (i[7:2] == WIDE_IDX_BASE[7:2]) begin
      r = {3'b110, 2'b00, i[1:0]};
    end
    return r;
  endfunction

endpackage

// ### verification/psc_tb.sv
// self-checking bench for the per-port statistics counter bank
// assumes psc_pkg and psc_stats are compiled first; bench is the axi master
`timescale 1ns/10ps
`default_nettype none
module testbench import psc_pkg::*;;
  // ****************************************
  // stimulus signals, named as the ports
  // ****************************************
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [NPORT-1:0] rx_valid = '0, rx_crc_ok = '0, rx_sym_err = '0;
  logic [NPORT-1:0] rx_odd_bits = '0, rx_preamble_ok = '0, rx_high_prio = '0;
  logic [NPORT-1:0] rx_bcast = '0, rx_mcast = '0, rx_ctrl_type = '0;
  logic [NPORT-1:0] rx_halt_da_op = '0, rx_drop = '0, tx_valid = '0;
  logic [NPORT-1:0] tx_ok = '0, tx_high_prio = '0, tx_bcast = '0;
  logic [NPORT-1:0] tx_mcast = '0, tx_ctrl_type = '0, tx_halt_da_op = '0;
  logic [NPORT-1:0] tx_late = '0, tx_waited = '0, tx_half_duplex = '0;
  logic [NPORT-1:0] tx_abort = '0, tx_drop = '0;
  logic [NPORT-1:0][LEN_W-1:0] rx_len = '0, tx_len = '0;
  logic [NPORT-1:0][4:0] tx_clashes = '0;
  logic [31:0] cfg [NPORT];
  int fail_count = 0;
  int n_tests = 0;

  psc_stats dut (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .rx_valid, .rx_len, .rx_crc_ok,
    .rx_sym_err, .rx_odd_bits, .rx_preamble_ok, .rx_high_prio, .rx_bcast,
    .rx_mcast, .rx_ctrl_type, .rx_halt_da_op, .rx_drop, .tx_valid, .tx_len,
    .tx_ok, .tx_high_prio, .tx_bcast, .tx_mcast, .tx_ctrl_type,
    .tx_halt_da_op, .tx_late, .tx_waited, .tx_half_duplex, .tx_clashes,
    .tx_abort, .tx_drop);

  // 25 mhz core clock
  always #20 clk = ~clk;

  // ****************************************
  // verdict, compare and bus tasks
  // ****************************************
  task automatic close_out();
    if (fail_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // a lost handshake ends the run at once
  task automatic hang();
    fail_count++;
    $display("wrong value at %0t: no answer from slave", $time);
    close_out();
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin @(posedge clk); n++; end while (s_axi_awready !== 1'b1 && n < 50);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do begin @(posedge clk); n++; end while (s_axi_bvalid !== 1'b1 && n < 50);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 50) hang();
    @(posedge clk);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin @(posedge clk); n++; end while (s_axi_arready !== 1'b1 && n < 50);
    s_axi_arvalid <= 1'b0;
    do begin @(posedge clk); n++; end while (s_axi_rvalid !== 1'b1 && n < 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 50) hang();
    @(posedge clk);
  endtask

  function automatic logic [11:0] pa(input int p);
    return 12'h100 + 12'(8 * p);
  endfunction

  // indirect counter read: request, poll until done, fetch data
  task automatic cnt(input int p, input logic [7:0] i,
                     output logic [31:0] d, output logic [31:0] c);
    logic [1:0] r;
    int n;
    wr(pa(p), cfg[p] | {8'h02, i, 16'h0000}, r);
    n = 0;
    do begin rd(pa(p), c, r); n++; end while (c[CS_REQ] !== 1'b0 && n < 20);
    if (n >= 20) hang();
    rd(pa(p) + 12'h004, d, r);
  endtask

  task automatic ex(input int p, input logic [7:0] i, input logic [31:0] e);
    logic [31:0] d;
    logic [31:0] c;
    cnt(p, i, d, c);
    chk(d, e);
  endtask

  // one frame on port p; flags crc,sym,odd,pre,hp,bc,mc,ctl,halt,drop
  task automatic rx(input int p, input logic [15:0] len, input logic [9:0] f);
    rx_valid <= NPORT'(1) << p;
    rx_len <= {NPORT{len}};
    rx_crc_ok <= {NPORT{f[9]}};
    rx_sym_err <= {NPORT{f[8]}};
    rx_odd_bits <= {NPORT{f[7]}};
    rx_preamble_ok <= {NPORT{f[6]}};
    rx_high_prio <= {NPORT{f[5]}};
    rx_bcast <= {NPORT{f[4]}};
    rx_mcast <= {NPORT{f[3]}};
    rx_ctrl_type <= {NPORT{f[2]}};
    rx_halt_da_op <= {NPORT{f[1]}};
    rx_drop <= {NPORT{f[0]}};
    @(posedge clk);
    rx_valid <= '0;
    @(posedge clk);
  endtask

  // flags ok,hp,bc,mc,ctl,halt,late,waited,half,abort,drop
  task automatic tx(input int p, input logic [15:0] len,
                    input logic [10:0] f, input logic [4:0] k);
    tx_valid <= NPORT'(1) << p;
    tx_len <= {NPORT{len}};
    tx_ok <= {NPORT{f[10]}};
    tx_high_prio <= {NPORT{f[9]}};
    tx_bcast <= {NPORT{f[8]}};
    tx_mcast <= {NPORT{f[7]}};
    tx_ctrl_type <= {NPORT{f[6]}};
    tx_halt_da_op <= {NPORT{f[5]}};
    tx_late <= {NPORT{f[4]}};
    tx_waited <= {NPORT{f[3]}};
    tx_half_duplex <= {NPORT{f[2]}};
    tx_abort <= {NPORT{f[1]}};
    tx_drop <= {NPORT{f[0]}};
    tx_clashes <= {NPORT{k}};
    @(posedge clk);
    tx_valid <= '0;
    @(posedge clk);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [31:0] d;
    logic [31:0] c;
    logic [1:0] r;
    longint oct;
    logic [15:0] bin_len [8] = '{64, 127, 128, 511, 1023, 1522, 1523, 2001};
    logic [7:0] err_idx [12] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
                                 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h82};
    logic [7:0] tx_idx [9] = '{8'h18, 8'h19, 8'h1E, 8'h1F, 8'h1B, 8'h1D,
                               8'h16, 8'h17, 8'h83};
    for (int p = 0; p < NPORT; p++) cfg[p] = 32'h0000_0000;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    // reset values and unmapped places
    rd(GLOBAL_OFS, d, r);
    chk(d, 32'h0000_0000);
    rd(12'h200, d, r);
    chk({d[29:0], r}, {30'h0, RESP_SLVERR});
    wr(12'h138, 32'hFFFF_FFFF, r);
    chk(32'(r), 32'(RESP_SLVERR));
    // good high-priority unicast frame, then read-clear
    rx(0, 16'h0040, 10'h260);
    ex(0, 8'h00, 32'h0000_0040);
    ex(0, 8'h0C, 32'h0000_0001);
    ex(0, 8'h0C, 32'h0000_0000);
    ex(0, 8'h80, 32'h0000_0040);
    ex(0, 8'h40, 32'h0000_0000);
    // length bins at their boundaries
    foreach (bin_len[i]) rx(1, bin_len[i], 10'h240);
    foreach (bin_len[i]) ex(1, 8'h0D + 8'(i), 32'h1);
    // error classes and frame kinds, one frame each
    rx(2, 16'd60, 10'h240);
    rx(2, 16'd60, 10'h040);
    rx(2, 16'd1530, 10'h240);
    rx(2, 16'd1600, 10'h040);
    rx(2, 16'd100, 10'h040);
    rx(2, 16'd100, 10'h0C0);
    rx(2, 16'd100, 10'h340);
    rx(2, 16'd64, 10'h24E);
    rx(2, 16'd64, 10'h258);
    rx(2, 16'd64, 10'h248);
    rx(2, 16'd64, 10'h241);
    foreach (err_idx[i]) ex(2, err_idx[i], 32'h1);
    // long maximum size selected
    cfg[4] = 32'h0400_0000;
    wr(pa(4), cfg[4], r);
    rx(4, 16'd1530, 10'h240);
    rx(4, 16'd1700, 10'h040);
    rx(4, 16'd1950, 10'h240);
    ex(4, 8'h03, 32'h1);
    ex(4, 8'h04, 32'h1);
    // transmit side
    tx(5, 16'd100, 11'h700, 5'd0);
    tx(5, 16'd64, 11'h460, 5'd0);
    tx(5, 16'd64, 11'h480, 5'd0);
    tx(5, 16'd64, 11'h404, 5'd1);
    tx(5, 16'd64, 11'h40C, 5'd3);
    tx(5, 16'd64, 11'h012, 5'd2);
    tx(5, 16'd64, 11'h001, 5'd0);
    foreach (tx_idx[i]) ex(5, tx_idx[i], 32'h1);
    ex(5, 8'h15, 32'd100);
    ex(5, 8'h1C, 32'd4);
    ex(5, 8'h81, 32'd484);
    // freeze and flush only on the enabled port
    cfg[6] = 32'h0100_0000;
    wr(pa(6), cfg[6], r);
    wr(GLOBAL_OFS, 32'h40, r);
    rx(6, 16'd64, 10'h240);
    rx(0, 16'd64, 10'h240);
    ex(6, 8'h0D, 32'h0);
    // port 0 also holds the 64-byte frame of the first scenario
    ex(0, 8'h0D, 32'h2);
    wr(GLOBAL_OFS, 32'h00, r);
    rx(6, 16'd64, 10'h240);
    wr(GLOBAL_OFS, 32'hC0, r);
    rd(GLOBAL_OFS, d, r);
    chk(d, 32'hC0);
    ex(6, 8'h0D, 32'h0);
    wr(GLOBAL_OFS, 32'h00, r);
    rx(6, 16'd64, 10'h240);
    ex(6, 8'h0D, 32'h1);
    // long burst of maximum frames wraps the narrow octet counter
    rx_len <= {NPORT{16'hFFFF}};
    rx_high_prio <= '1;
    rx_valid <= NPORT'(1) << 3;
    repeat (65538) @(posedge clk);
    rx_valid <= '0;
    @(posedge clk);
    oct = 64'd65538 * 64'd65535;
    rd(pa(3), c, r);
    chk(32'(c[CS_OVF]), 32'h1);
    ex(3, 8'h00, 32'(oct % (64'd1 << NARROW_W)));
    cnt(3, 8'h80, d, c);
    chk(d, oct[31:0]);
    chk({c[CS_OVF], c[3:0]}, {1'b0, oct[35:32]});
    close_out();
  end
endmodule
`default_nettype wire
